// [hdl/fws_bus_cycle.sv]
// one asynchronous read or write cycle on the flash pins
// assumes the flash meets its timing within the held cycle count
`timescale 1ns/1ns
`default_nettype none
`include "fws_regs.svh"
module fws_bus_cycle
  import fws_pkg::*;
#(
  parameter int RD_CYC = `FWS_RD_CYCLES,
  parameter int WR_CYC = `FWS_WR_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire fws_cyc_t    cyc,
  input  wire logic [7:0]  dataIn,
  output var  logic        busy,
  output var  logic        done,
  output var  logic [7:0]  rdata,
  output var  logic [16:0] flashAddr,
  output var  logic [7:0]  dataOut,
  output var  logic        dataOe,
  output var  logic        chipEn_n,
  output var  logic        outEn_n,
  output var  logic        writeEn_n
);
  // the four-bit cycle counter caps both counts
  if (RD_CYC < 2 || WR_CYC < 2 || RD_CYC > 15 || WR_CYC > 15) begin : g_bad
    $error("cycle counts out of range");
  end

  logic [3:0] count;
  logic       isWrite;

  default clocking cyc_cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      count     <= 4'h0;
      isWrite   <= 1'b0;
      rdata     <= 8'h00;
      flashAddr <= 17'h00000;
      dataOut   <= 8'h00;
      dataOe    <= 1'b0;
      chipEn_n  <= 1'b1;
      outEn_n   <= 1'b1;
      writeEn_n <= 1'b1;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy      <= 1'b1;
        isWrite   <= cyc.write;
        count     <= 4'h0;
        flashAddr <= cyc.addr;
        dataOut   <= cyc.wdata;
        dataOe    <= cyc.write;
        chipEn_n  <= 1'b0;
        outEn_n   <= cyc.write;
        writeEn_n <= ~cyc.write;
      end else if (busy) begin
        count <= count + 4'h1;
        // sample at the end so every read is a distinct flash cycle
        if (count == 4'(isWrite ? WR_CYC - 1 : RD_CYC - 1)) begin
          busy      <= 1'b0;
          done      <= 1'b1;
          rdata     <= dataIn;
          chipEn_n  <= 1'b1;
          outEn_n   <= 1'b1;
          writeEn_n <= 1'b1;
          dataOe    <= 1'b0;
        end
      end
    end
  end

  strobes_excl_a: assert property (!(~outEn_n && ~writeEn_n)) // [R22]
    else $error("read and write strobes overlap");
  drive_write_a: assert property (dataOe |-> ~writeEn_n) // [R22]
    else $error("data driven outside a write");
endmodule // fws_bus_cycle
`default_nettype wire

// [hdl/fws_pkg.sv]
// types shared by the flash write-status poller files
// assumes fws_regs.svh supplies the numeric constants
package fws_pkg;
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0]  wdata;
    logic        write;
  } fws_cyc_t;

  typedef enum logic [3:0] {
    FWS_IDLE    = 4'h0,
    FWS_READ1   = 4'h1,
    FWS_READ2   = 4'h2,
    FWS_CHKFAIL = 4'h3,
    FWS_READ3   = 4'h4,
    FWS_READ4   = 4'h5,
    FWS_RESET   = 4'h6,
    FWS_DONE    = 4'h7,
    FWS_WINRD   = 4'h8,
    FWS_FAIL    = 4'h9
  } fws_state_t;

  typedef struct packed {
    logic ok;
    logic failed;
    logic windowOpen;
  } fws_result_t;
endpackage

// [hdl/fws_poller.sv]
// flash write-status poller: toggle-bit check, fail reset, erase window
// assumes the flash sits on the pins and inputs are core_clk synchronous
//
// Summary of operation
// R1: start polling with two back-to-back reads
// R2: toggle stopped means done; array readable
// R3: toggling: look at fail bit, recheck
// R4: still toggling with fail: failed, reset
// R5: restart procedure from first double read
// R6: device raises fail bit past pulse limit
// R7: device halts bad program, raises fail bit
// R8: reset command after any fail indication; code resets only when the recheck still toggles
// R9: device window bit low during acceptance timeout
// R10: device restarts timeout per extra erase
// R11: commands under 50 us apart skip window
// R12: device ignores commands once window high
// R13: device accepts more erases while low
// R14: check window bit before and after command
// R15: device suspended-sector status encoding
// R16: device returns array data outside sector
// R17: poll at programmed or erasing address
// R18: device complements polled data while programming
// R19: device polling bit low while erasing
// R20: device toggle one inverts while busy
// R21: device toggle two inverts in erase sectors
// R22: device drives bus only with enables
`timescale 1ns/1ns
`default_nettype none
`include "fws_regs.svh"
module fws_poller
  import fws_pkg::*;
#(
  parameter int RD_CYC = `FWS_RD_CYCLES,
  parameter int WR_CYC = `FWS_WR_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        pollStart,
  input  wire logic        windowCheck,
  input  wire logic        abortPoll,
  input  wire logic [16:0] pollAddr,
  input  wire logic [7:0]  flashDataIn,
  output var  logic [16:0] flashAddr,
  output var  logic [7:0]  flashDataOut,
  output var  logic        flashDataOe,
  output var  logic        flashCe_n,
  output var  logic        flashOe_n,
  output var  logic        flashWe_n,
  output var  logic        busy,
  output var  fws_result_t result,
  output var  logic        resultValid,
  output var  logic [7:0]  lastStatus
);
  if (RD_CYC < 2 || WR_CYC < 2) begin : g_bad_cyc
    $error("cycle counts too small");
  end

  fws_state_t state;
  fws_cyc_t   cyc;
  logic       cycStart;
  logic       cycBusy;
  logic       cycDone;
  logic [7:0] cycData;
  logic       firstToggle;
  logic       failSeen;

  default clocking poll_cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  fws_bus_cycle #(.RD_CYC(RD_CYC), .WR_CYC(WR_CYC)) u_cycle (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .start     (cycStart),
    .cyc       (cyc),
    .dataIn    (flashDataIn),
    .busy      (cycBusy),
    .done      (cycDone),
    .rdata     (cycData),
    .flashAddr (flashAddr),
    .dataOut   (flashDataOut),
    .dataOe    (flashDataOe),
    .chipEn_n  (flashCe_n),
    .outEn_n   (flashOe_n),
    .writeEn_n (flashWe_n)
  );

  logic toggled;
  assign toggled = cycData[`FWS_TOGGLE_ONE_POS] != firstToggle;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= FWS_IDLE;
      cycStart    <= 1'b0;
      cyc         <= '0;
      firstToggle <= 1'b0;
      failSeen    <= 1'b0;
      busy        <= 1'b0;
      result      <= '0;
      resultValid <= 1'b0;
      lastStatus  <= 8'h00;
    end else begin
      cycStart    <= 1'b0;
      resultValid <= 1'b0;
      case (state)
        FWS_IDLE: begin
          if (pollStart) begin
            // always from the first double read, even after a pause [R5]
            state     <= FWS_READ1;  // [R1]
            busy      <= 1'b1;
            failSeen  <= 1'b0;
            cyc       <= '{addr: pollAddr, wdata: 8'h00, write: 1'b0}; // [R17]
            cycStart  <= 1'b1;
          end else if (windowCheck) begin
            // reads the flag every time, no 50 us spacing assumed [R11]
            state    <= FWS_WINRD;  // [R14]
            busy     <= 1'b1;
            cyc      <= '{addr: pollAddr, wdata: 8'h00, write: 1'b0};
            cycStart <= 1'b1;
          end
        end
        FWS_WINRD: begin
          if (cycDone) begin
            lastStatus        <= cycData;
            result            <= '0;
            result.windowOpen <= ~cycData[`FWS_ERASE_WIN_POS]; // [R14]
            resultValid       <= 1'b1;
            busy              <= 1'b0;
            state             <= FWS_IDLE;
          end
        end
        FWS_READ1, FWS_READ3: begin
          if (cycDone) begin
            firstToggle <= cycData[`FWS_TOGGLE_ONE_POS];
            lastStatus  <= cycData;
            cycStart    <= 1'b1;
            state <= (state == FWS_READ1) ? FWS_READ2 : FWS_READ4; // [R1]
          end
        end
        FWS_READ2: begin
          if (cycDone) begin
            lastStatus <= cycData;
            if (!toggled) begin
              state <= FWS_DONE;  // [R2]
            end else if (cycData[`FWS_TIMEOUT_POS]) begin
              failSeen <= 1'b1;  // [R3]
              cycStart <= 1'b1;
              state    <= FWS_READ3;
            end else if (abortPoll) begin
              // leaving here forces a fresh double read next time [R5]
              state <= FWS_IDLE;
              busy  <= 1'b0;
            end else begin
              cycStart <= 1'b1;
              state    <= FWS_READ1;
            end
          end
        end
        FWS_READ4: begin
          if (cycDone) begin
            lastStatus <= cycData;
            if (!toggled) begin
              state <= FWS_DONE;  // [R3]
            end else begin
              // failed op: reset restores array reads [R4] [R8]
              cyc      <= '{addr: `FWS_RESET_ADDR, wdata: `FWS_RESET_DATA,
                            write: 1'b1};
              cycStart <= 1'b1;
              state    <= FWS_RESET;
            end
          end
        end
        FWS_RESET: begin
          if (cycDone) begin
            state <= FWS_FAIL;
          end
        end
        FWS_DONE: begin
          result      <= '{ok: 1'b1, failed: 1'b0, windowOpen: 1'b0}; // [R2]
          resultValid <= 1'b1;
          busy        <= 1'b0;
          state       <= FWS_IDLE;
        end
        FWS_FAIL: begin
          result      <= '{ok: 1'b0, failed: 1'b1, windowOpen: 1'b0}; // [R4]
          resultValid <= 1'b1;
          busy        <= 1'b0;
          state       <= FWS_IDLE;
        end
        default: begin
          state <= FWS_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  sequence fail_recheck_s;
    state == FWS_READ2 && cycDone && toggled && cycData[`FWS_TIMEOUT_POS];
  endsequence

  sequence reset_write_s;
    state == FWS_RESET ##1 !flashWe_n ##0 flashDataOut == `FWS_RESET_DATA;
  endsequence

  fail_recheck_a: assert property ( // [R3]
    fail_recheck_s |=> state == FWS_READ3)
    else $error("no recheck after fail bit seen");
  reset_write_a: assert property ( // [R8]
    state == FWS_FAIL |-> $past(state) == FWS_RESET)
    else $error("fail reported without reset command");
  reset_cmd_a: assert property ( // [R4]
    state == FWS_READ4 && cycDone && toggled |=> reset_write_s)
    else $error("reset command not written");
  fail_first_a: assert property (state == FWS_RESET |-> failSeen) // [R8]
    else $error("reset issued without fail bit");
  double_read_a: assert property ( // [R1] [R5]
    state == FWS_IDLE && pollStart |=> state == FWS_READ1)
    else $error("poll did not start with double read");
  done_stop_a: assert property ( // [R2]
    state == FWS_READ2 && cycDone && !toggled |=> ##1 resultValid && result.ok)
    else $error("stopped toggle not reported done");
  ok_nofail_a: assert property ( // [R4]
    resultValid |-> !(result.ok && result.failed))
    else $error("result both ok and failed");
  window_a: assert property ( // [R14]
    state == FWS_WINRD && cycDone |=> resultValid &&
      result.windowOpen == !$past(cycData[`FWS_ERASE_WIN_POS]))
    else $error("window bit misreported");
  one_cycle_a: assert property (cycStart |=> !cycStart) // [R1]
    else $error("cycle start held");
endmodule // fws_poller
`default_nettype wire

// [hdl/fws_regs.svh]
// constants for the flash write-status poller
// assumes one core clock at 10 MHz and an 8-bit parallel flash bus
`ifndef FWS_REGS_SVH
`define FWS_REGS_SVH
`define FWS_DATA_POLL_POS   7
`define FWS_TOGGLE_ONE_POS  6
`define FWS_TIMEOUT_POS     5
`define FWS_ERASE_WIN_POS   3
`define FWS_TOGGLE_TWO_POS  2
`define FWS_CLK_NS          100
`define FWS_RESET_ADDR      17'h00000
`define FWS_RESET_DATA      8'hf0
`define FWS_RD_CYCLES       3
`define FWS_WR_CYCLES       3
`define FWS_WINDOW_US       50
`define FWS_WINDOW_CYC      ((`FWS_WINDOW_US * 1000) / `FWS_CLK_NS)
`endif

// [tb/fws_flash_model.sv]
// behavioural flash device answering status reads of the poller
// assumes active low strobes held steady through each cycle
`timescale 1ns/1ns
`default_nettype none
`include "fws_regs.svh"
module fws_flash_model (
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  dataIn,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        ld,
  input  wire logic [7:0]  ldCnt,
  input  wire logic        ldFail,
  input  wire logic        ldWin,
  input  wire logic [1:0]  ldMode,
  input  wire logic [7:0]  arrData,
  output var  logic [7:0]  dq,
  output var  int          rstSeen
);
  logic [7:0] cnt = 8'h00;
  logic [7:0] stat;
  logic [7:0] lastDq = 8'h00;
  logic       fail = 1'b0;
  logic       win = 1'b0;
  logic       tog = 1'b0;
  logic       rdEnd;
  // mode 0 program, 1 sector erase, 2 erase suspended
  localparam logic [4:0] SECT = 5'h01;
  logic [1:0] mode = 2'h0;
  logic       inSect;
  initial rstSeen = 0;
  assign rdEnd = ce_n | oe_n;
  // top five address bits pick the sector
  assign inSect = addr[16:12] == SECT;
  always_comb begin
    stat = arrData;
    if (mode == 2'h2) begin
      if (inSect) begin
        stat[`FWS_DATA_POLL_POS] = 1'b1;
        stat[`FWS_TOGGLE_ONE_POS] = 1'b0;
        stat[`FWS_TIMEOUT_POS] = 1'b0;
        stat[`FWS_TOGGLE_TWO_POS] = tog;
      end
    end else if (cnt != 8'h00) begin
      // erase shows 0, program the complement
      stat[`FWS_DATA_POLL_POS] = (mode == 2'h1) ? 1'b0
                                 : ~arrData[`FWS_DATA_POLL_POS];
      stat[`FWS_TOGGLE_ONE_POS] = tog;
      // overrun or a bad 0-to-1 program both end here
      stat[`FWS_TIMEOUT_POS] = fail;
      stat[`FWS_ERASE_WIN_POS] = win;
      if (mode == 2'h1 && inSect) begin
        stat[`FWS_TOGGLE_TWO_POS] = tog;
      end
    end
  end
  // released bus shows the inverse, so a stale sample cannot pass
  assign dq = (!ce_n && !oe_n) ? stat : ~lastDq;
  always @(posedge rdEnd) begin
    lastDq <= stat;
    if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      tog <= ~tog;
    end else if (mode == 2'h2 && inSect) begin
      tog <= ~tog;
    end
  end
  always @(posedge ld) begin
    #1;
    cnt <= ldCnt;
    fail <= ldFail;
    win <= ldWin; // a reload low restarts the timeout
    mode <= ldMode;
  end
  always @(negedge we_n) begin
    #1;
    // a running erase with its window shut and no fault ignores the command
    if (!ce_n && dataIn === `FWS_RESET_DATA
        && addr === `FWS_RESET_ADDR && !(mode == 2'h1 && win && !fail)) begin
      cnt <= 8'h00;
      mode <= 2'h0;
      fail <= 1'b0;
      rstSeen <= rstSeen + 1;
    end
  end
endmodule // fws_flash_model
`default_nettype wire

// [tb/test_flash_write_status_reporting.sv]
// self-checking bench for the flash write-status poller
// assumes the behavioural flash model stands on the flash pins
`timescale 1ns/1ns
`default_nettype none
`include "fws_regs.svh"
module test_flash_write_status_reporting;
  import fws_pkg::*;
  localparam logic [7:0] ARR = 8'h5a;
  localparam logic [7:0] TG1_MASK = 8'h01 << `FWS_TOGGLE_ONE_POS;
  localparam logic [7:0] TG2_MASK = 8'h01 << `FWS_TOGGLE_TWO_POS;
  logic [1:0]  ldMode = 2'h0;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        pollStart = 1'b0;
  logic        windowCheck = 1'b0;
  logic        abortPoll = 1'b0;
  logic [16:0] pollAddr = 17'h01234;
  logic        ld = 1'b0;
  logic [7:0]  ldCnt = 8'h00;
  logic        ldFail = 1'b0;
  logic        ldWin = 1'b0;
  logic [7:0]  flashDataIn, flashDataOut, lastStatus;
  logic [16:0] flashAddr;
  logic        flashDataOe, flashCe_n, flashOe_n, flashWe_n;
  logic        busy, resultValid;
  fws_result_t result;
  int          rstSeen, errorCnt = 0, numChecks = 0, rs0;

  fws_poller uut (.core_clk(core_clk), .sys_rst(sys_rst),
    .pollStart(pollStart), .windowCheck(windowCheck),
    .abortPoll(abortPoll), .pollAddr(pollAddr),
    .flashDataIn(flashDataIn), .flashAddr(flashAddr),
    .flashDataOut(flashDataOut), .flashDataOe(flashDataOe),
    .flashCe_n(flashCe_n), .flashOe_n(flashOe_n),
    .flashWe_n(flashWe_n), .busy(busy), .result(result),
    .resultValid(resultValid), .lastStatus(lastStatus));
  fws_flash_model dev (.addr(flashAddr), .dataIn(flashDataOut),
    .ce_n(flashCe_n), .oe_n(flashOe_n), .we_n(flashWe_n), .ld(ld),
    .ldCnt(ldCnt), .ldFail(ldFail), .ldWin(ldWin), .ldMode(ldMode),
    .arrData(ARR),
    .dq(flashDataIn), .rstSeen(rstSeen));

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic closeOut;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      errorCnt++;
    end
  endtask

  task automatic loadDev(input logic [7:0] c, input logic f,
                         input logic w);
    @(posedge core_clk);
    ldCnt <= c;
    ldFail <= f;
    ldWin <= w;
    ld <= 1'b1;
    @(posedge core_clk);
    ld <= 1'b0;
  endtask

  // bounded wait: a stuck poll ends the run as a mismatch
  task automatic request(input logic win);
    int n;
    @(posedge core_clk);
    if (win) windowCheck <= 1'b1;
    else pollStart <= 1'b1;
    @(posedge core_clk);
    windowCheck <= 1'b0;
    pollStart <= 1'b0;
    for (n = 0; n < 4000 && resultValid !== 1'b1; n++) @(posedge core_clk);
    if (n == 4000) begin
      errorCnt++;
      closeOut();
    end
  endtask

  task automatic t_done;
    loadDev(8'h00, 1'b0, 1'b0);
    request(1'b0);
    chk("ok", 8'h01, {7'h00, result.ok});
    chk("status", ARR, lastStatus);
    chk("ce idle", 8'h01, {7'h00, flashCe_n});
    $display("test done_at_once finished");
  endtask

  task automatic t_toggle;
    loadDev(8'h05, 1'b0, 1'b0);
    request(1'b0);
    chk("ok", 8'h01, {7'h00, result.ok});
    chk("status", ARR, lastStatus);
    $display("test toggle_then_stop finished");
  endtask

  task automatic t_failStop;
    rs0 = rstSeen;
    loadDev(8'h02, 1'b1, 1'b0);
    request(1'b0);
    chk("failed", 8'h00, {7'h00, result.failed});
    chk("ok", 8'h01, {7'h00, result.ok});
    chk("resets", 8'(rs0), 8'(rstSeen));
    $display("test fail_bit_but_stopped finished");
  endtask

  task automatic t_failStuck;
    rs0 = rstSeen;
    loadDev(8'hc8, 1'b1, 1'b0);
    request(1'b0);
    chk("failed", 8'h01, {7'h00, result.failed});
    chk("resets", 8'(rs0 + 1), 8'(rstSeen));
    chk("data drive idle", 8'h00, {7'h00, flashDataOe});
    chk("we idle", 8'h01, {7'h00, flashWe_n});
    $display("test fail_stuck_reset finished");
  endtask

  task automatic t_abort;
    int n;
    int seen;
    seen = 0;
    loadDev(8'hc8, 1'b0, 1'b0);
    abortPoll <= 1'b1;
    pollStart <= 1'b1;
    @(posedge core_clk);
    pollStart <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (resultValid === 1'b1) seen++;
    end
    chk("abort result", 8'h00, 8'(seen));
    chk("abort busy", 8'h00, {7'h00, busy});
    abortPoll <= 1'b0;
    loadDev(8'h00, 1'b0, 1'b0);
    request(1'b0);
    chk("restart ok", 8'h01, {7'h00, result.ok});
    $display("test abort_restart finished");
  endtask

  task automatic t_window;
    loadDev(8'h32, 1'b0, 1'b0);
    request(1'b1);
    chk("window open", 8'h01, {7'h00, result.windowOpen});
    loadDev(8'h32, 1'b0, 1'b1);
    request(1'b1);
    chk("window shut", 8'h00, {7'h00, result.windowOpen});
    $display("test erase_window finished");
  endtask

  task automatic t_erase;
    logic [7:0] s;
    ldMode <= 2'h1;
    loadDev(8'h06, 1'b0, 1'b0);
    request(1'b1);
    s = lastStatus;
    chk("erase poll bit", 8'h00, {7'h00, s[`FWS_DATA_POLL_POS]});
    request(1'b1);
    chk("erase toggle two", TG2_MASK, (s ^ lastStatus) & TG2_MASK);
    chk("erase toggle one", TG1_MASK, (s ^ lastStatus) & TG1_MASK);
    request(1'b0);
    chk("erase ok", 8'h01, {7'h00, result.ok});
    chk("erase status", ARR, lastStatus);
    $display("test sector_erase finished");
  endtask

  task automatic t_suspend;
    logic [7:0] s;
    ldMode <= 2'h2;
    loadDev(8'h00, 1'b0, 1'b0);
    request(1'b0);
    chk("suspend ok", 8'h01, {7'h00, result.ok});
    s = lastStatus;
    chk("suspend poll bit", 8'h01, {7'h00, s[`FWS_DATA_POLL_POS]});
    chk("suspend fail bit", 8'h00, {7'h00, s[`FWS_TIMEOUT_POS]});
    request(1'b1);
    s = lastStatus;
    request(1'b1);
    chk("suspend toggle two", TG2_MASK, (s ^ lastStatus) & TG2_MASK);
    chk("suspend toggle one", 8'h00, (s ^ lastStatus) & TG1_MASK);
    pollAddr <= 17'h05678;
    request(1'b0);
    chk("outside sector", ARR, lastStatus);
    pollAddr <= 17'h01234;
    ldMode <= 2'h0;
    $display("test erase_suspend finished");
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_done();
    t_toggle();
    t_failStop();
    t_failStuck();
    t_abort();
    t_window();
    t_erase();
    t_suspend();
    closeOut();
  end
endmodule // test_flash_write_status_reporting
`default_nettype wire
